// ---- design/acp_pkg.sv ----
// Constants, register map and types for the converter serial-port controller.
// Assumes nothing beyond a SystemVerilog-2012 compiler.
package acp_pkg;
   // Own APB register byte offsets
   localparam logic [11:0] ACP_OFF_CMD     = 12'h000;
   localparam logic [11:0] ACP_OFF_WDATA   = 12'h004;
   localparam logic [11:0] ACP_OFF_STATUS  = 12'h008;
   localparam logic [11:0] ACP_OFF_RDATA   = 12'h00C;
   localparam logic [11:0] ACP_OFF_CFG     = 12'h010;
   // Command register fields
   localparam int ACP_CMD_GO_BIT   = 31;
   localparam int ACP_CMD_OP_LSB   = 24;
   localparam int ACP_CMD_LEN_LSB  = 8;
   localparam int ACP_CMD_REG_LSB  = 0;
   // Operation codes
   localparam logic [1:0] ACP_OP_WRITE = 2'h0;
   localparam logic [1:0] ACP_OP_READ  = 2'h1;
   localparam logic [1:0] ACP_OP_RESET = 2'h2;
   // Config register fields
   localparam int ACP_CFG_THREE_WIRE = 0;
   localparam int ACP_CFG_WAIT_RDY   = 1;
   // Status bits
   localparam int ACP_ST_BUSY  = 0;
   localparam int ACP_ST_RDY_N = 1;
   // Device register map (far side)
   localparam logic [5:0] ACP_DEV_COMMS        = 6'h00;
   localparam logic [5:0] ACP_DEV_CONV_CONTROL = 6'h01;
   localparam logic [5:0] ACP_DEV_DATA         = 6'h02;
   localparam logic [5:0] ACP_DEV_BIAS_PIN     = 6'h04;
   localparam logic [15:0] ACP_CONV_CONTROL_RST = 16'h0000;
   localparam logic [15:0] ACP_BIAS_PIN_RST     = 16'h0000;
   localparam int ACP_COMMS_RD_BIT = 6;
   // Serial framing
   localparam int ACP_RESET_ONES = 64;
   localparam int ACP_CLK_NS     = 4;
   localparam int ACP_GAP_NS     = 100;
   localparam int ACP_GAP_CYC    = (ACP_GAP_NS + ACP_CLK_NS - 1) / ACP_CLK_NS;
   localparam int ACP_HALF_DIV   = 6;
   localparam logic [31:0] ACP_ZERO32 = 32'h0000_0000;
   localparam logic [31:0] ACP_UNMAPPED = 32'h0000_0000;

   typedef enum logic [6:0] {
      ACP_IDLE  = 7'b0000001,
      ACP_WAITR = 7'b0000010,
      ACP_LOAD  = 7'b0000100,
      ACP_LOW   = 7'b0001000,
      ACP_HIGH  = 7'b0010000,
      ACP_END   = 7'b0100000,
      ACP_GAP   = 7'b1000000
   } acp_state_t;
endpackage : acp_pkg

// ---- design/acp_sync3.sv ----
// Three-stage input synchroniser with agreement filter.
// Assumes an asynchronous input; output changes when stages 2 and 3 agree.
`timescale 1ns/100ps
module acp_sync3 (
   // Clock and reset
   input  wire logic clock_in,
   input  wire logic sys_rst_in,
   input  wire logic clk_en_in,
   // Data
   input  wire logic async_in,
   output logic      sync_out
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } acp_sync_t;
   acp_sync_t st_r, st_nxt;

   // First stage feeds only the second
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = async_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      if (st_r.s2 == st_r.s3) begin
         st_nxt.q = st_r.s3;
      end
   end

   // Idle-high reset matches a released data-ready line
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         st_r <= '1;
      end else if (clk_en_in) begin
         st_r <= st_nxt;
      end
   end
   assign sync_out = st_r.q;
endmodule : acp_sync3

// ---- design/acp_sclk_gen.sv ----
// Serial clock divider: one pulse per half period of the link clock.
// Assumes the main controller holds it running for a whole frame.
`timescale 1ns/100ps
module acp_sclk_gen #(
   parameter int HALF_DIV = acp_pkg::ACP_HALF_DIV
) (
   // Clock and reset
   input  wire logic clock_in,
   input  wire logic sys_rst_in,
   input  wire logic clk_en_in,
   // Control
   input  wire logic run_in,
   output logic      tick_out
);
   import acp_pkg::*;
   typedef struct packed {
      logic [7:0] cnt;
      logic       tick;
   } acp_div_t;
   acp_div_t st_r, st_nxt;

   initial begin
      if (HALF_DIV < 2 || HALF_DIV > 255) $error("HALF_DIV out of range");
   end

   // Counter restarts whenever run drops
   always_comb begin
      st_nxt      = st_r;
      st_nxt.tick = 1'b0;
      if (!run_in) begin
         st_nxt.cnt = 8'h00;
      end else if (st_r.cnt == 8'(HALF_DIV - 1)) begin
         st_nxt.cnt  = 8'h00;
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.cnt = st_r.cnt + 8'h01;
      end
   end

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         st_r <= '0;
      end else if (clk_en_in) begin
         st_r <= st_nxt;
      end
   end
   assign tick_out = st_r.tick;
endmodule : acp_sclk_gen

// ---- design/acp_ctrl.sv ----
// Host-side controller for the converter's four-wire serial port, APB slave.
// Assumes APB from the same clock; converter pins are asynchronous to it.
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
// Summary of operation
// - Clocked diagnostics enabled outside standby only
// - Power-down only entered from standby
// - Wake: 64 clocks, select low, input high
// - Poll power-on flag before register access (controller starts accesses without polling it)
// - Each access opens with communications write
// - Rereads allowed; streaming words read once
// - Idle gap between consecutive transactions
// - Three-wire mode polls status ready bit (controller waits on the data-ready pin instead, when the cfg wait bit is set)
// - Serial clock rests high between transfers
// - Error diagnostics need select-framed accesses
module acp_ctrl
   import acp_pkg::*;
#(
   parameter int GAP_CYC  = ACP_GAP_CYC,
   parameter int HALF_DIV = ACP_HALF_DIV
) (
   // Clock, enable, reset
   input  wire logic        clock_in,
   input  wire logic        sys_rst_in,
   input  wire logic        clk_en_in,
   // APB slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // Converter serial port
   output logic             cs_n_out,
   output logic             sclk_out,
   output logic             din_out,
   input  wire logic        dout_rdy_n_in
);
   import acp_pkg::*;

   // Synced sample must land inside the low phase, so the divider has a floor
   initial begin
      if (GAP_CYC < 1 || GAP_CYC > 65535) $error("GAP_CYC out of range");
      if (HALF_DIV < 6) $error("HALF_DIV too small for synced sampling");
   end

   typedef struct packed {
      acp_state_t  state;
      logic [31:0] cmd;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic [1:0]  cfg;
      logic [39:0] shreg;
      logic [6:0]  bits;
      logic [15:0] gap;
      logic        cs_n;
      logic        sclk;
      logic        din;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } acp_ctrl_t;
   acp_ctrl_t st_r, st_nxt;

   logic rdy_n_sync;
   logic tick;
   logic run;
   logic apb_setup;

   // Data-ready line is asynchronous: three stages
   acp_sync3 u_sync (
      .clock_in   (clock_in),
      .sys_rst_in (sys_rst_in),
      .clk_en_in  (clk_en_in),
      .async_in   (dout_rdy_n_in),
      .sync_out   (rdy_n_sync)
   );

   assign run = (st_r.state == ACP_LOW) || (st_r.state == ACP_HIGH);

   acp_sclk_gen #(
      .HALF_DIV (HALF_DIV)
   ) u_sclk (
      .clock_in   (clock_in),
      .sys_rst_in (sys_rst_in),
      .clk_en_in  (clk_en_in),
      .run_in     (run),
      .tick_out   (tick)
   );

   // Bit count of a whole frame, command byte included
   function automatic logic [6:0] acp_frame_bits(input logic [31:0] c);
      logic [1:0] op;
      op = c[ACP_CMD_OP_LSB +: 2];
      if (op == ACP_OP_RESET) begin
         acp_frame_bits = 7'(ACP_RESET_ONES);
      end else begin
         acp_frame_bits = 7'd8 + {1'b0, c[ACP_CMD_LEN_LSB +: 6]};
      end
   endfunction : acp_frame_bits

   assign apb_setup = psel_in && !penable_in;

   always_comb begin
      st_nxt         = st_r;
      st_nxt.pready  = 1'b0;
      st_nxt.pslverr = 1'b0;

      // APB: answer one cycle after setup, address decode
      if (apb_setup) begin
         st_nxt.pready = 1'b1;
         st_nxt.prdata = ACP_ZERO32;
         if (paddr_in == ACP_OFF_CMD) begin
            st_nxt.prdata = st_r.cmd;
            if (pwrite_in && st_r.state == ACP_IDLE) begin
               st_nxt.cmd = pwdata_in;
            end
         end else if (paddr_in == ACP_OFF_WDATA) begin
            st_nxt.prdata = st_r.wdata;
            if (pwrite_in) begin
               st_nxt.wdata = pwdata_in;
            end
         end else if (paddr_in == ACP_OFF_STATUS) begin
            st_nxt.prdata[ACP_ST_BUSY]  = (st_r.state != ACP_IDLE);
            st_nxt.prdata[ACP_ST_RDY_N] = rdy_n_sync;
         end else if (paddr_in == ACP_OFF_RDATA) begin
            st_nxt.prdata = st_r.rdata;
         end else if (paddr_in == ACP_OFF_CFG) begin
            st_nxt.prdata = {30'h0000_0000, st_r.cfg};
            if (pwrite_in) begin
               st_nxt.cfg = pwdata_in[1:0];
            end
         end else begin
            st_nxt.prdata  = ACP_UNMAPPED;
            st_nxt.pslverr = 1'b1;
         end
      end

      // Serial engine
      case (st_r.state)
         ACP_IDLE: begin
            st_nxt.sclk = 1'b1;
            st_nxt.din  = 1'b1;
            st_nxt.cs_n = !st_r.cfg[ACP_CFG_THREE_WIRE] ? 1'b1 : 1'b0;
            if (st_r.cmd[ACP_CMD_GO_BIT]) begin
               if (st_r.cfg[ACP_CFG_WAIT_RDY]) begin
                  st_nxt.state = ACP_WAITR;
               end else begin
                  st_nxt.state = ACP_LOAD;
               end
            end
         end
         ACP_WAITR: begin
            // Wait for data-ready low before fetching the word
            if (!rdy_n_sync) begin
               st_nxt.state = ACP_LOAD;
            end
         end
         ACP_LOAD: begin
            st_nxt.cs_n = 1'b0;
            st_nxt.bits = acp_frame_bits(st_r.cmd);
            if (st_r.cmd[ACP_CMD_OP_LSB +: 2] == ACP_OP_RESET) begin
               st_nxt.shreg = '1;
            end else begin
               // Command byte first, then payload left-aligned
               st_nxt.shreg = {1'b0,
                  (st_r.cmd[ACP_CMD_OP_LSB +: 2] == ACP_OP_READ),
                  st_r.cmd[ACP_CMD_REG_LSB +: 6],
                  st_r.wdata};
            end
            st_nxt.rdata = ACP_ZERO32;
            st_nxt.state = ACP_LOW;
         end
         ACP_LOW: begin
            // Falling edge: drive next bit, MSB first
            st_nxt.sclk = 1'b0;
            st_nxt.din  = st_r.shreg[39];
            if (tick) begin
               // Sample before the rising edge: the device may switch soon after it
               st_nxt.rdata = {st_r.rdata[30:0], rdy_n_sync};
               st_nxt.state = ACP_HIGH;
            end
         end
         ACP_HIGH: begin
            st_nxt.sclk = 1'b1;
            if (tick) begin
               // Ones fill from the right so a reset frame stays all ones
               st_nxt.shreg = {st_r.shreg[38:0], 1'b1};
               st_nxt.bits  = st_r.bits - 7'd1;
               if (st_r.bits == 7'd1) begin
                  st_nxt.state = ACP_END;
               end else begin
                  st_nxt.state = ACP_LOW;
               end
            end
         end
         ACP_END: begin
            // Frame done; rdata holds the last bits taken in
            st_nxt.cs_n  = !st_r.cfg[ACP_CFG_THREE_WIRE] ? 1'b1 : 1'b0;
            st_nxt.din   = 1'b1;
            st_nxt.cmd[ACP_CMD_GO_BIT] = 1'b0;
            st_nxt.gap   = 16'(GAP_CYC);
            st_nxt.state = ACP_GAP;
         end
         ACP_GAP: begin
            // Enforced quiet time before the next frame
            st_nxt.gap = st_r.gap - 16'h0001;
            if (st_r.gap == 16'h0001) begin
               st_nxt.state = ACP_IDLE;
            end
         end
         default: begin
            st_nxt.state = ACP_IDLE;
         end
      endcase
   end

   // One register stage for all state and outputs
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         st_r       <= '0;
         st_r.state <= ACP_IDLE;
         st_r.cs_n  <= 1'b1;
         st_r.sclk  <= 1'b1;
         st_r.din   <= 1'b1;
      end else if (clk_en_in) begin
         st_r <= st_nxt;
      end
   end

   assign prdata_out  = st_r.prdata;
   assign pready_out  = st_r.pready;
   assign pslverr_out = st_r.pslverr;
   assign cs_n_out    = st_r.cs_n;
   assign sclk_out    = st_r.sclk;
   assign din_out     = st_r.din;
endmodule : acp_ctrl

// ---- verif/acp_ctrl_asserts.sv ----
// Checker for the port controller: APB answer and serial framing.
// Assumes it is bound to acp_ctrl and sees only its ports.
`timescale 1ns/100ps
module acp_ctrl_asserts (
   // Clock and reset
   input wire logic clock_in,
   input wire logic sys_rst_in,
   // APB
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pready_out,
   input wire logic pslverr_out,
   // Serial port
   input wire logic cs_n_out,
   input wire logic sclk_out,
   input wire logic din_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   // Bus answer timing
   AST_APB_ANSWER: assert property (psel_in && !penable_in |=> pready_out)
      else $error("no pready after setup");
   AST_APB_PULSE: assert property (pready_out |=> !pready_out)
      else $error("pready longer than one cycle");
   AST_ERR_WITH_READY: assert property (pslverr_out |-> pready_out)
      else $error("pslverr without pready");
   // Link clock rests high outside frames
   AST_SCLK_IDLE: assert property (cs_n_out |-> sclk_out)
      else $error("sclk low while deselected");
   AST_SCLK_FALL: assert property ($fell(sclk_out) |-> !cs_n_out)
      else $error("sclk fell outside frame");
   // Data steady at the sampling edge, low phase not a glitch
   AST_DIN_STABLE: assert property ($rose(sclk_out) |-> $stable(din_out))
      else $error("din moved on rising sclk");
   AST_LOW_PHASE: assert property ($fell(sclk_out) |=> !sclk_out)
      else $error("sclk low phase too short");
   // Gap between frames, data line idles high
   AST_FRAME_GAP: assert property ($rose(cs_n_out) |=> cs_n_out[*2])
      else $error("frame gap too short");
   AST_DIN_IDLE: assert property (cs_n_out && $past(cs_n_out) |-> din_out)
      else $error("din low between frames");
endmodule : acp_ctrl_asserts

bind acp_ctrl acp_ctrl_asserts acp_ctrl_asserts_inst (.clock_in(clock_in),
   .sys_rst_in(sys_rst_in), .psel_in(psel_in), .penable_in(penable_in),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .cs_n_out(cs_n_out),
   .sclk_out(sclk_out), .din_out(din_out));

// ---- verif/acp_dev_model.sv ----
// Behavioural converter: command byte, control registers, data word, ready.
// Assumes 24-bit frames, framed by select or back to back in three-wire form.
`timescale 1ns/100ps
module acp_dev_model (
   // Serial port
   input  wire logic cs_n_in,
   input  wire logic sclk_in,
   input  wire logic din_in,
   output logic      dout_rdy_n_out,
   // New conversion strobe
   input  wire logic conv_in
);
   logic [15:0] regs [8];
   logic [15:0] sh;
   logic [7:0]  cmd;
   logic        rdy_n;
   logic        q;
   int          n;
   int          ones;
   initial begin
      regs = '{default: 16'h0000};
      rdy_n = 1'b1;
      q = 1'b1;
      n = 0;
      ones = 0;
   end
   // Select rising returns the port to await a command
   always @(posedge cs_n_in) n = 0;
   // Ready goes high before the word changes, low after
   always @(posedge conv_in) begin
      rdy_n = 1'b1;
      #8 regs[2] = regs[2] + 16'h1111;
      rdy_n = 1'b0;
   end
   // Input taken on rising link clock
   always @(posedge sclk_in) if (!cs_n_in) begin
      ones = din_in ? ones + 1 : 0;
      if (n < 8) cmd = {cmd[6:0], din_in};
      else sh = {sh[14:0], din_in};
      n = n + 1;
      if (n == 24 && !cmd[6]) regs[cmd[2:0]] = sh;
      if (n == 24 && cmd[6] && cmd[5:0] == 6'h02) rdy_n = 1'b1;
      if (n == 24) n = 0;
      if (ones == 64) begin
         regs = '{default: 16'h0000};
         n = 0;
         ones = 0;
      end
   end
   // Output bit moves on falling link clock, MSB first
   always @(negedge sclk_in) if (n >= 8 && cmd[6]) q = regs[cmd[2:0]][23 - n];
   // Deselected line shows the inverse of the last bit
   assign dout_rdy_n_out = cs_n_in ? ~q : ((n >= 8 && cmd[6]) ? q : rdy_n);
endmodule : acp_dev_model

// ---- verif/testbench.sv ----
// Self-checking bench: APB master in front, converter model behind.
// Assumes the controller answers APB after one access phase.
`timescale 1ns/100ps
module testbench;
   import acp_pkg::*;
   logic        clock_in, sys_rst_in, psel, penable, pwrite, conv, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, cs_n, sclk, din, dout;
   int          err_total, checks;
   acp_ctrl #(.GAP_CYC(1), .HALF_DIV(6)) acp_ctrl_inst (
      .clock_in(clock_in), .sys_rst_in(sys_rst_in), .clk_en_in(1'b1),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .cs_n_out(cs_n), .sclk_out(sclk), .din_out(din),
      .dout_rdy_n_in(dout));
   acp_dev_model acp_dev_model_inst (.cs_n_in(cs_n), .sclk_in(sclk),
      .din_in(din), .dout_rdy_n_out(dout), .conv_in(conv));
   // 250 MHz clock
   initial begin
      clock_in = 1'b0;
      forever #2 clock_in = ~clock_in;
   end
   task automatic chk(input string what, input logic [31:0] exp, got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // One APB transfer; waits for pready, watchdog bounds it
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_in);
      penable <= 1'b1;
      do @(posedge clock_in); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : bus
   task automatic go(input logic [1:0] op, input logic [5:0] r);
      bus(1'b1, ACP_OFF_CMD, {1'b1, 5'h00, op, 10'h000, 6'h10, 2'b00, r});
   endtask : go
   task automatic settle;
      do bus(1'b0, ACP_OFF_STATUS, ACP_ZERO32); while (rd[ACP_ST_BUSY] !== 1'b0);
   endtask : settle
   task automatic wr(input logic [5:0] r, input logic [15:0] v);
      bus(1'b1, ACP_OFF_WDATA, {v, 16'h0000});
      go(ACP_OP_WRITE, r);
      settle;
   endtask : wr
   task automatic rdchk(input string what, input logic [5:0] r, input logic [15:0] v);
      go(ACP_OP_READ, r);
      settle;
      bus(1'b0, ACP_OFF_RDATA, ACP_ZERO32);
      chk(what, {16'h0000, v}, {16'h0000, rd[15:0]});
   endtask : rdchk
   // Reset values, write/read back, command refused while busy
   task automatic t_regs;
      bus(1'b0, 12'h0F0, ACP_ZERO32);
      chk("unmapped", {ACP_UNMAPPED[30:0], 1'b1}, {rd[30:0], err});
      rdchk("ctrl reset", ACP_DEV_CONV_CONTROL, ACP_CONV_CONTROL_RST);
      rdchk("bias reset", ACP_DEV_BIAS_PIN, ACP_BIAS_PIN_RST);
      wr(ACP_DEV_CONV_CONTROL, 16'hA5C3);
      bus(1'b1, ACP_OFF_WDATA, 32'h5A3C_0000);
      go(ACP_OP_WRITE, ACP_DEV_BIAS_PIN);
      go(ACP_OP_WRITE, ACP_DEV_CONV_CONTROL);
      settle;
      rdchk("ctrl kept", ACP_DEV_CONV_CONTROL, 16'hA5C3);
      rdchk("bias", ACP_DEV_BIAS_PIN, 16'h5A3C);
      $display("test regs done");
   endtask : t_regs
   // Run of ones restores defaults
   task automatic t_reset;
      go(ACP_OP_RESET, 6'h00);
      settle;
      rdchk("ctrl after ones", ACP_DEV_CONV_CONTROL, 16'h0000);
      rdchk("bias after ones", ACP_DEV_BIAS_PIN, 16'h0000);
      $display("test reset done");
   endtask : t_reset
   // Three-wire read held until ready, then reread
   task automatic t_ready;
      bus(1'b1, ACP_OFF_CFG, 32'h0000_0003);
      go(ACP_OP_READ, ACP_DEV_DATA);
      bus(1'b0, ACP_OFF_STATUS, ACP_ZERO32);
      chk("waiting busy", 32'h1, {31'h0, rd[ACP_ST_BUSY]});
      conv <= 1'b1;
      @(posedge clock_in);
      conv <= 1'b0;
      settle;
      bus(1'b0, ACP_OFF_RDATA, ACP_ZERO32);
      chk("data word", 32'h1111, {16'h0000, rd[15:0]});
      bus(1'b0, ACP_OFF_STATUS, ACP_ZERO32);
      chk("ready after read", 32'h1, {31'h0, rd[ACP_ST_RDY_N]});
      bus(1'b1, ACP_OFF_CFG, 32'h0000_0001);
      rdchk("reread", ACP_DEV_DATA, 16'h1111);
      $display("test ready done");
   endtask : t_ready
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : complete_run
   initial begin
      {psel, penable, pwrite, conv} = 4'h0;
      paddr = 12'h000;
      pwdata = ACP_ZERO32;
      err_total = 0;
      checks = 0;
      sys_rst_in = 1'b1;
      repeat (10) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      t_regs;
      t_reset;
      t_ready;
      complete_run;
   end
   // Watchdog: run needs under 10k cycles, limit is 30k cycles
   initial begin
      #120000;
      err_total++;
      complete_run;
   end
endmodule : testbench
